// ==== rapf_defines.svh ====
// Register offsets, field positions, reset values and timing counts for
// the alarm and periodic flag block of the real-time clock.
// Assumes inclusion by bare name from the design files.
`ifndef RAPF_DEFINES_SVH
`define RAPF_DEFINES_SVH

// Register offsets on the plain register port (byte addresses)
`define RAPF_OFS_ALARM_CTRL   4'h0
`define RAPF_OFS_PERIOD_CTRL  4'h1
`define RAPF_OFS_CMP_ENABLE   4'h2
`define RAPF_OFS_SEC_CMP      4'h3
`define RAPF_OFS_MIN_CMP      4'h4
`define RAPF_OFS_HOUR_CMP     4'h5
`define RAPF_OFS_WDAY_CMP     4'h6
`define RAPF_OFS_DAY_CMP      4'h7
`define RAPF_OFS_MON_CMP      4'h8
`define RAPF_OFS_YEAR_CMP     4'h9
`define RAPF_OFS_IRQ_STATUS   4'ha
`define RAPF_OFS_IRQ_MASK     4'hb

// Field positions
`define RAPF_BIT_ALARM_FLAG   0
`define RAPF_BIT_ALARM_IE     3
`define RAPF_BIT_PERIOD_FLAG  7
`define RAPF_BIT_PERIOD_RSVD  3
`define RAPF_PSEL_HI          6
`define RAPF_PSEL_LO          4

// Reset values
`define RAPF_RST_ALARM_CTRL   8'h00
`define RAPF_RST_PERIOD_CTRL  8'h08
`define RAPF_RST_CMP          8'h00

// Timing: system clock rate and the 256 Hz base tick
`define RAPF_SYS_CLK_HZ       10000000
`define RAPF_BASE_TICK_HZ     256
`define RAPF_BASE_DIV         (`RAPF_SYS_CLK_HZ / `RAPF_BASE_TICK_HZ)

`endif

// ==== rapf_pkg.sv ====
// Types shared by the alarm and periodic flag block.
// Assumes rapf_defines.svh is reachable on the include path.
package rapf_pkg;

    // Calendar time as seen by the alarm comparator
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } rapf_time_s;

    // Plain register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rapf_req_s;

    // Periodic interval selections
    typedef enum logic [2:0] {
        RAPF_PER_OFF,
        RAPF_PER_256,
        RAPF_PER_64,
        RAPF_PER_16,
        RAPF_PER_4,
        RAPF_PER_2,
        RAPF_PER_1S,
        RAPF_PER_2S
    } rapf_period_e;

endpackage

// ==== rapf_prescaler.sv ====
// Prescaler chain: a 256 Hz base tick divided down to 1 Hz, and a
// one-cycle strobe for each stage.
// Assumes sys_clk at the rate given in the defines header.
`timescale 1ns/1ps
`default_nettype none
`include "rapf_defines.svh"

module rapf_prescaler
    import rapf_pkg::*;
#(
    parameter int BASE_DIV = `RAPF_BASE_DIV
) (
    input  wire logic       sys_clk,   // System clock
    input  wire logic       arst_n,    // Async reset, active low
    output logic      [8:0] stageTick  // Bit n: 256 Hz / 2**n strobe
);

    logic [$clog2(BASE_DIV)-1:0] baseCnt_q;
    logic [8:0]                  chain_q;
    logic                        baseTick;

    assign baseTick = (baseCnt_q == ($clog2(BASE_DIV))'(BASE_DIV - 1));

    // Base divider from the system clock
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            baseCnt_q <= '0;
        end else if (baseTick) begin
            baseCnt_q <= '0;
        end else begin
            baseCnt_q <= baseCnt_q + 1'b1;
        end
    end

    // Binary chain; a stage strobes when all lower stages wrap
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_q <= '0;
        end else if (baseTick) begin
            chain_q <= chain_q + 9'h001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : gTick
            if (g == 0) begin : gBase
                assign stageTick[g] = baseTick;
            end else begin : gUp
                assign stageTick[g] = baseTick && (&chain_q[g-1:0]);
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== rapf_alarm_cmp.sv ====
// Alarm comparator: matches enabled calendar fields against compare
// values and strobes once per counter update.
// Assumes the counter update strobe is one cycle long on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module rapf_alarm_cmp
    import rapf_pkg::*;
(
    input  wire logic       sys_clk,    // System clock
    input  wire logic       arst_n,     // Async reset, active low
    input  wire rapf_time_s curTime,    // Current calendar counters
    input  wire rapf_time_s cmpTime,    // Alarm compare values
    input  wire logic [6:0] cmpOn,      // Per-field compare enables
    input  wire logic       cntUpdate,  // Counters just updated
    output logic            matchPulse  // One-cycle match strobe
);

    logic [6:0] fieldHit;
    logic       pending_q;

    // Field-by-field equality, disabled fields count as hit
    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : gField
            assign fieldHit[g] = !cmpOn[g] ||
                (curTime[g*8 +: 8] == cmpTime[g*8 +: 8]);
        end
    endgenerate

    // Evaluate one cycle after the update so counters have settled
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= cntUpdate;
        end
    end

    // No enabled field means no alarm at all
    assign matchPulse = pending_q && (|cmpOn) && (&fieldHit);

endmodule
`default_nettype wire

// ==== rapf_top.sv ====
// Alarm-match and periodic-interrupt flag logic of a real-time clock,
// with its register file and a summary interrupt output.
// Assumes calendar counters and their update strobe come from the RTC
// counting logic on sys_clk; one clock, one asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "rapf_defines.svh"

module rapf_top
    import rapf_pkg::*;
#(
    parameter int BASE_DIV = `RAPF_BASE_DIV
) (
    input  wire logic       sys_clk,      // 10 MHz system clock
    input  wire logic       arst_n,       // Async reset, active low
    input  wire logic [3:0] regAddr,      // Register address
    input  wire logic [7:0] regWdata,     // Register write data
    input  wire logic       regWr,        // Write strobe
    input  wire logic       regRd,        // Read strobe
    output logic      [7:0] regRdata,     // Read data, cycle after strobe
    input  wire rapf_time_s curTime,      // Calendar counters
    input  wire logic       cntUpdate,    // Counter update strobe
    output logic            alarmIrq,     // Alarm request
    output logic            periodicIrq,  // Periodic request
    output logic            irq           // Summary interrupt
);

    rapf_req_s  req;
    rapf_time_s cmpTime_q;
    logic [6:0] cmpOn_q;
    logic       alarmFlag_q;
    logic       alarmIe_q;
    logic       perFlag_q;
    logic [2:0] perSel_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqMask_q;
    logic [7:0] regRdata_q;
    logic [8:0] stageTick;
    logic       matchPulse;
    logic       perTick;
    logic       wrAlarm;
    logic       wrPer;
    logic       wrStat;

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // Write decode shared by the control, enable, status and mask registers
    function automatic logic hitWr(input rapf_req_s r,
                                   input logic [3:0] ofs);
        hitWr = r.wr && (r.addr == ofs);
    endfunction

    assign wrAlarm = hitWr(req, `RAPF_OFS_ALARM_CTRL);
    assign wrPer   = hitWr(req, `RAPF_OFS_PERIOD_CTRL);
    assign wrStat  = hitWr(req, `RAPF_OFS_IRQ_STATUS);

    rapf_prescaler #(
        .BASE_DIV (BASE_DIV)
    ) uPresc (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .stageTick (stageTick)
    );

    rapf_alarm_cmp uCmp (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .curTime    (curTime),
        .cmpTime    (cmpTime_q),
        .cmpOn      (cmpOn_q),
        .cntUpdate  (cntUpdate),
        .matchPulse (matchPulse)
    );

    // Interval select to prescaler stage; 1/2 s is stage 7, 1 s stage 8;
    // 2 s needs one more halving below
    logic perHalf_q;
    always_comb begin
        case (rapf_period_e'(perSel_q))
            RAPF_PER_OFF: perTick = 1'b0;
            RAPF_PER_256: perTick = stageTick[0];
            RAPF_PER_64:  perTick = stageTick[2];
            RAPF_PER_16:  perTick = stageTick[4];
            RAPF_PER_4:   perTick = stageTick[6];
            RAPF_PER_2:   perTick = stageTick[7];
            RAPF_PER_1S:  perTick = stageTick[8];
            RAPF_PER_2S:  perTick = stageTick[8] && perHalf_q;
            default:      perTick = 1'b0;
        endcase
    end

    // Extra halving for the 2 s interval, off the prescaler's last stage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            perHalf_q <= 1'b0;
        end else if (stageTick[8]) begin
            perHalf_q <= !perHalf_q;
        end
    end

    // Alarm flag: match sets, a written 0 clears, a written 1 holds
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarmFlag_q <= 1'b0;
        end else if (matchPulse) begin
            alarmFlag_q <= 1'b1;
        end else if (wrAlarm && !req.wdata[`RAPF_BIT_ALARM_FLAG]) begin
            alarmFlag_q <= 1'b0;
        end
    end

    // Alarm interrupt enable
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarmIe_q <= 1'b0;
        end else if (wrAlarm) begin
            alarmIe_q <= req.wdata[`RAPF_BIT_ALARM_IE];
        end
    end

    // Periodic flag: interval or written 1 sets; event beats a clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            perFlag_q <= 1'b0;
        end else if (perTick) begin
            perFlag_q <= 1'b1;
        end else if (wrPer) begin
            perFlag_q <= req.wdata[`RAPF_BIT_PERIOD_FLAG];
        end
    end

    // Periodic interval select
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            perSel_q <= 3'h0;
        end else if (wrPer) begin
            perSel_q <= req.wdata[`RAPF_PSEL_HI:`RAPF_PSEL_LO];
        end
    end

    // Alarm compare values, one field per register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmpTime_q <= '0;
        end else if (req.wr) begin
            case (req.addr)
                `RAPF_OFS_SEC_CMP:  cmpTime_q.seconds <= req.wdata;
                `RAPF_OFS_MIN_CMP:  cmpTime_q.minutes <= req.wdata;
                `RAPF_OFS_HOUR_CMP: cmpTime_q.hours   <= req.wdata;
                `RAPF_OFS_WDAY_CMP: cmpTime_q.weekday <= req.wdata;
                `RAPF_OFS_DAY_CMP:  cmpTime_q.day     <= req.wdata;
                `RAPF_OFS_MON_CMP:  cmpTime_q.month   <= req.wdata;
                `RAPF_OFS_YEAR_CMP: cmpTime_q.year    <= req.wdata;
                default:            cmpTime_q         <= cmpTime_q;
            endcase
        end
    end

    // Per-field compare enables
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmpOn_q <= 7'h00;
        end else if (hitWr(req, `RAPF_OFS_CMP_ENABLE)) begin
            cmpOn_q <= req.wdata[6:0];
        end
    end

    // Sticky status: events set, write-one clears, set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_q <= 2'h0;
        end else begin
            irqStat_q <= (irqStat_q & ~(wrStat ? req.wdata[1:0] : 2'h0))
                       | {perTick, matchPulse};
        end
    end

    // Summary mask
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqMask_q <= 2'h0;
        end else if (hitWr(req, `RAPF_OFS_IRQ_MASK)) begin
            irqMask_q <= req.wdata[1:0];
        end
    end

    // Requests are levels: the periodic one is its flag, the alarm one its flag and enable
    assign alarmIrq    = alarmFlag_q && alarmIe_q;
    assign periodicIrq = perFlag_q;
    assign irq         = |(irqStat_q & irqMask_q);

    // Read mux; unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `RAPF_OFS_ALARM_CTRL:
                    regRdata_q <= {4'h0, alarmIe_q, 2'h0, alarmFlag_q};
                `RAPF_OFS_PERIOD_CTRL:
                    regRdata_q <= {perFlag_q, perSel_q, 1'b1, 3'h0};
                `RAPF_OFS_CMP_ENABLE: regRdata_q <= {1'b0, cmpOn_q};
                `RAPF_OFS_SEC_CMP:    regRdata_q <= cmpTime_q.seconds;
                `RAPF_OFS_MIN_CMP:    regRdata_q <= cmpTime_q.minutes;
                `RAPF_OFS_HOUR_CMP:   regRdata_q <= cmpTime_q.hours;
                `RAPF_OFS_WDAY_CMP:   regRdata_q <= cmpTime_q.weekday;
                `RAPF_OFS_DAY_CMP:    regRdata_q <= cmpTime_q.day;
                `RAPF_OFS_MON_CMP:    regRdata_q <= cmpTime_q.month;
                `RAPF_OFS_YEAR_CMP:   regRdata_q <= cmpTime_q.year;
                `RAPF_OFS_IRQ_STATUS: regRdata_q <= {6'h00, irqStat_q};
                `RAPF_OFS_IRQ_MASK:   regRdata_q <= {6'h00, irqMask_q};
                default:              regRdata_q <= 8'h00;
            endcase
        end else begin
            regRdata_q <= 8'h00;
        end
    end

    assign regRdata = regRdata_q;

endmodule
`default_nettype wire

// ==== rapf_monitor.sv ====
// Checker for the alarm and periodic flag block, bound to rapf_top.
// Assumes one clock domain and only the top module's ports.
`timescale 1ns/1ps
`default_nettype none

module rapf_monitor (
    input wire logic       sys_clk,     // System clock
    input wire logic       arst_n,      // Async reset, active low
    input wire logic [3:0] regAddr,     // Register address
    input wire logic [7:0] regWdata,    // Write data
    input wire logic       regWr,       // Write strobe
    input wire logic       regRd,       // Read strobe
    input wire logic [7:0] regRdata,    // Read data
    input wire logic       cntUpdate,   // Counter update strobe
    input wire logic       alarmIrq,    // Alarm request
    input wire logic       periodicIrq, // Periodic request
    input wire logic       irq          // Summary interrupt
);
    logic       aie_q;   // Alarm enable as last written
    logic [2:0] psel_q;  // Interval select as last written

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Shadows of writes, since register bodies are not visible here
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aie_q  <= 1'b0;
            psel_q <= 3'h0;
        end else if (regWr && regAddr == 4'h0) begin
            aie_q <= regWdata[3];
        end else if (regWr && regAddr == 4'h1) begin
            psel_q <= regWdata[6:4];
        end
    end

    rd_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    rsvd_reads_one_a:
        assert property ($past(regRd && regAddr == 4'h1) |-> regRdata[3])
        else $error("reserved bit read as zero");
    pflag_read_a: assert property ($past(regRd && regAddr == 4'h1)
        |-> regRdata[7] == $past(periodicIrq))
        else $error("periodic request differs from its flag");
    pflag_set_a: assert property (regWr && regAddr == 4'h1
        && regWdata[7] |=> periodicIrq) else $error("periodic flag not set");
    pflag_clear_a: assert property (regWr && regAddr == 4'h1
        && regWdata[7:4] == 4'h0 && psel_q == 3'h0 |=> !periodicIrq)
        else $error("periodic flag not cleared");
    aflag_gate_a: assert property (alarmIrq |-> aie_q)
        else $error("alarm request while disabled");
    aflag_read_a: assert property ($past(regRd && regAddr == 4'h0
        && alarmIrq) |-> regRdata[0]) else $error("alarm flag reads zero");
    aflag_clear_a: assert property (regWr && regAddr == 4'h0
        && !regWdata[0] && !$past(cntUpdate) && !$past(cntUpdate, 2)
        && !$past(cntUpdate, 3) |=> !alarmIrq)
        else $error("alarm flag not cleared");
    aflag_keep_a: assert property (regWr && regAddr == 4'h0
        && regWdata[0] && regWdata[3] && alarmIrq |=> alarmIrq)
        else $error("alarm flag lost on write of one");
    arise_cause_a: assert property ($rose(alarmIrq) |->
        $past(cntUpdate, 2) || $past(cntUpdate, 3)
        || $past(regWr && regAddr == 4'h0))
        else $error("alarm request rose without cause");

    cover property ($rose(alarmIrq));
    cover property ($rose(periodicIrq));
    cover property ($rose(irq));
endmodule

bind rapf_top rapf_monitor u_mon (
    .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .cntUpdate(cntUpdate), .alarmIrq(alarmIrq),
    .periodicIrq(periodicIrq), .irq(irq)
);
`default_nettype wire

// ==== test_rtc_alarm_periodic_flags.sv ====
// Self-checking bench for the alarm and periodic flag block.
// Assumes rapf_top with a short base divider and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module test_rtc_alarm_periodic_flags
    import rapf_pkg::*;
;
    localparam int DIV   = 4;      // Short base tick keeps the run brief
    localparam int LIMIT = 20000;  // Ceiling for a hung run
    localparam int MUL [8] = '{0, 1, 4, 16, 64, 128, 256, 512};
    logic       sys_clk     = 1'b0;
    logic       arst_n      = 1'b0;
    logic [3:0] regAddr     = 4'h0;
    logic [7:0] regWdata    = 8'h00;
    logic       regWr       = 1'b0;
    logic       regRd       = 1'b0;
    logic [7:0] regRdata;
    rapf_time_s curTime     = '0;
    logic       cntUpdate   = 1'b0;
    logic       alarmIrq;
    logic       periodicIrq;
    logic       irq;
    rapf_time_s t;
    logic [6:0] en;
    logic       m;
    logic [7:0] d;
    logic [63:0] r;
    int         n;
    int         n_errors    = 0;
    int         n_compared  = 0;
    int         cyc         = 0;
    integer     seed        = 32'h2106b1ba;

    rapf_top #(.BASE_DIV(DIV)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .curTime(curTime), .cntUpdate(cntUpdate),
        .alarmIrq(alarmIrq), .periodicIrq(periodicIrq), .irq(irq)
    );

    always #50 sys_clk = ~sys_clk;

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            n_errors++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    // Strobes launch and drop on rising edges; return at the falling edge
    // so callers see settled outputs, and the idle cycle between calls
    // keeps any signal from being set twice in one time step
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= v;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        @(negedge sys_clk);
    endtask

    // Read data stand only in the cycle after the strobe: take them mid-cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        v = regRdata;
    endtask

    task automatic waitPer(input int lim, output int k);
        k = 0;
        while (periodicIrq !== 1'b1 && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
    endtask

    // Match only if some field is enabled and all enabled fields agree
    function automatic logic expMatch(input rapf_time_s c, input rapf_time_s a,
                                      input logic [6:0] e);
        logic x;
        x = (e != 7'h00);
        for (int i = 0; i < 7; i++)
            if (e[i] && c[8*i +: 8] != a[8*i +: 8]) x = 1'b0;
        return x;
    endfunction

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), d);
            chkv(d, (a == 1) ? 8'h08 : 8'h00);
        end
        chkv({5'h00, alarmIrq, periodicIrq, irq}, 8'h00);
        $display("test reset done");
        wr(4'h1, 8'h88);
        chkb(periodicIrq, 1'b1);
        rd(4'h1, d);
        chkv(d, 8'h88);
        wr(4'h1, 8'h08);
        chkb(periodicIrq, 1'b0);
        waitPer(200, n);
        chkn(n, 200);
        $display("test periodic flag done");
        wr(4'hb, 8'h02);
        for (int s = 1; s < 8; s++) begin
            wr(4'h1, {1'b0, 3'(s), 4'h8});
            waitPer(2 * DIV * MUL[s] + 4, n);
            wr(4'h1, {1'b0, 3'(s), 4'h8});
            waitPer(2 * DIV * MUL[s] + 4, n);
            // The clearing write lands two edges after the previous tick
            chkn(n + 2, DIV * MUL[s]);
        end
        wr(4'h1, 8'h08);
        chkb(irq, 1'b1);
        rd(4'ha, d);
        chkv(d, 8'h02);
        wr(4'hb, 8'h00);
        chkb(irq, 1'b0);
        wr(4'hb, 8'h01);
        wr(4'ha, 8'h02);
        rd(4'ha, d);
        chkv(d, 8'h00);
        $display("test intervals done");
        // Random times; even passes flip low bits of random fields
        for (int k = 0; k < 8; k++) begin
            r = {$random(seed), $random(seed)};
            t = r[55:0];
            en = (k == 0) ? 7'h00 : (k == 1) ? 7'h7f : 7'($random(seed));
            for (int i = 0; i < 7; i++) wr(4'(3 + i), t[8*i +: 8]);
            wr(4'h2, {1'b0, en});
            wr(4'h0, 8'h08);
            r = {$random(seed), $random(seed)} & 64'h01010101010101;
            @(posedge sys_clk);
            curTime <= k[0] ? t : t ^ r[55:0];
            cntUpdate <= 1'b1;
            @(posedge sys_clk);
            cntUpdate <= 1'b0;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            m = expMatch(curTime, t, en);
            chkb(alarmIrq, m);
            chkb(irq, m);
            rd(4'h0, d);
            chkv(d, {7'h04, m});
            wr(4'ha, 8'h01);
            chkb(irq, 1'b0);
            if (m) begin
                wr(4'h0, 8'h01);
                chkb(alarmIrq, 1'b0);
                wr(4'h0, 8'h09);
                chkb(alarmIrq, 1'b1);
                // A written 1 while the flag stands must leave it set
                wr(4'h0, 8'h09);
                chkb(alarmIrq, 1'b1);
                wr(4'h0, 8'h08);
                repeat (5) @(negedge sys_clk);
                chkb(alarmIrq, 1'b0);
            end
        end
        $display("test alarm done");
        finish_test();
    end
endmodule
`default_nettype wire
